// File: nvm_erase_and_icache_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
module nvm_erase_and_icache_ctrl_tb;
    import nvmec_pkg::*;
    localparam int MSC = 10;
    logic aclk, aresetn, ce, awvalid, awready, wvalid, wready;
    logic bvalid, bready, arvalid, arready, rvalid, rready;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata, nvm_wr_addr, nvm_wr_data, arr_addr, arr_wdata;
    logic [31:0] arr_rd_addr, arr_rd_data, fetch_addr, fetch_data;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic nvm_wr_req, nvm_wr_taken, arr_write, arr_page_erase;
    logic arr_partial_erase, arr_all_erase, arr_ucfg_erase;
    logic arr_rd_req, arr_rd_valid, fetch_req, fetch_ack, erase_cycle_done;
    logic [4:0] busy;
    int err_count, checked;
    assign busy = {arr_write, arr_ucfg_erase, arr_partial_erase,
        arr_all_erase, arr_page_erase};
    nvmec_ctrl #(.MS_CYCLES(MSC)) nvmec_ctrl_i (
        .aclk(aclk), .aresetn(aresetn), .ce(ce), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .nvm_wr_req(nvm_wr_req), .nvm_wr_addr(nvm_wr_addr),
        .nvm_wr_data(nvm_wr_data), .nvm_wr_taken(nvm_wr_taken),
        .arr_write(arr_write), .arr_page_erase(arr_page_erase),
        .arr_partial_erase(arr_partial_erase), .arr_all_erase(arr_all_erase),
        .arr_ucfg_erase(arr_ucfg_erase), .arr_addr(arr_addr),
        .arr_wdata(arr_wdata), .arr_rd_req(arr_rd_req),
        .arr_rd_addr(arr_rd_addr), .arr_rd_valid(arr_rd_valid),
        .arr_rd_data(arr_rd_data), .fetch_req(fetch_req),
        .fetch_addr(fetch_addr), .fetch_ack(fetch_ack),
        .fetch_data(fetch_data), .erase_cycle_done(erase_cycle_done));
    nvmec_flash_model nvmec_flash_model_i (
        .aclk(aclk), .aresetn(aresetn), .arr_rd_req(arr_rd_req),
        .arr_rd_addr(arr_rd_addr), .wipe(|busy[3:0]), .prog(arr_write),
        .arr_rd_valid(arr_rd_valid), .arr_rd_data(arr_rd_data));
    initial
    begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end
    task automatic print_verdict;
        $display("checks %0d errors %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic tmo;
        err_count++;
        $display("[FAIL] wait exp done got timeout");
        print_verdict();
    endtask
    task automatic chk(input string nm, input logic [31:0] s,
        input logic [31:0] e);
        checked++;
        if (s !== e)
        begin
            err_count++;
            $display("[FAIL] %s exp %h got %h", nm, e, s);
        end
    endtask
    function automatic logic [31:0] pat(input logic [31:0] a);
        return {a[15:0], ~a[15:0]};
    endfunction
    task automatic axi_wr(input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; !bvalid; n++)
        begin
            if (n > 50)
                tmo();
            @(posedge aclk);
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
        end
        bready <= 1'b0;
        chk("bresp", {30'h0, bresp}, {30'h0, RESP_OKAY});
    endtask
    task automatic rd_chk(input string nm, input logic [11:0] a,
        input logic [31:0] e, input logic [1:0] r);
        int n;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; !rvalid; n++)
        begin
            if (n > 50)
                tmo();
            @(posedge aclk);
            if (arready)
                arvalid <= 1'b0;
        end
        rready <= 1'b0;
        chk(nm, rdata, e);
        chk("rresp", {30'h0, rresp}, {30'h0, r});
    endtask
    task automatic measure(input int k, input int len, output logic dn);
        int n;
        n = 1;
        dn = 1'b0;
        while (busy[k])
        begin
            @(posedge aclk);
            dn = erase_cycle_done;
            if (busy[k])
                n++;
            if (n > 2000)
                tmo();
        end
        chk("op_len", 32'(n), 32'(len));
    endtask
    task automatic run_cmd(input logic [11:0] a, input logic [31:0] v,
        input int k, input int len, output logic dn);
        axi_wr(a, v);
        chk("op_start", 32'(busy[k]), 32'h1);
        chk("op_addr", arr_addr, v);
        measure(k, len, dn);
    endtask
    task automatic t_regs;
        rd_chk("dur_rst", OFS_PARTIAL_CFG, 32'h0000000A, RESP_OKAY);
        rd_chk("ccfg_rst", OFS_ICACHE_CFG, 32'h0, RESP_OKAY);
        rd_chk("hit_rst", OFS_HIT, 32'h0, RESP_OKAY);
        rd_chk("miss_rst", OFS_MISS, 32'h0, RESP_OKAY);
        rd_chk("wo_read", OFS_ALIAS_B, 32'h0, RESP_OKAY);
        rd_chk("unmapped", 12'h000, 32'h0, RESP_SLVERR);
    endtask
    task automatic t_erase;
        logic [11:0] ofs [5];
        int kk [5];
        int ln [5];
        logic dn;
        ofs = '{OFS_PAGE_ERASE, OFS_ALIAS_B, OFS_ERASE_ALL, OFS_UCFG_ERASE,
            OFS_PARTIAL};
        kk = '{0, 0, 1, 3, 2};
        ln = '{85 * MSC, 85 * MSC, 169 * MSC, 85 * MSC, 10 * MSC};
        axi_wr(OFS_PAGE_ERASE, 32'h1000);
        chk("no_mode", 32'(busy[0]), 32'h0);
        axi_wr(OFS_CONFIG, 32'h2);
        // only code-area page addresses are written
        for (int i = 0; i < 5; i++)
        begin
            run_cmd(ofs[i], 32'((i + 1) * 4096), kk[i], ln[i], dn);
            if (kk[i] < 2)
                chk("cyc_done", 32'(dn), 32'h1);
        end
    endtask
    task automatic t_partial;
        logic dn;
        axi_wr(OFS_PARTIAL_CFG, 32'h0000002B);
        rd_chk("dur_rw", OFS_PARTIAL_CFG, 32'h0000002B, RESP_OKAY);
        // two steps of 43 ms reach the full page time
        run_cmd(OFS_PARTIAL, 32'h8000, 2, 43 * MSC, dn);
        chk("part1", 32'(dn), 32'h0);
        run_cmd(OFS_PARTIAL, 32'h8000, 2, 43 * MSC, dn);
        chk("part2", 32'(dn), 32'h1);
    endtask
    task automatic t_word;
        int n;
        logic dn;
        axi_wr(OFS_CONFIG, 32'h1);
        @(posedge aclk);
        nvm_wr_addr <= 32'h2004;
        nvm_wr_data <= 32'hA5A50F0F;
        nvm_wr_req <= 1'b1;
        for (n = 0; !nvm_wr_taken; n++)
        begin
            if (n > 50)
                tmo();
            @(posedge aclk);
        end
        nvm_wr_req <= 1'b0;
        chk("wr_addr", arr_addr, 32'h2004);
        chk("wr_data", arr_wdata, 32'hA5A50F0F);
        measure(4, 410, dn);
    endtask
    task automatic fetch(input logic [31:0] e, output int n);
        @(posedge aclk);
        fetch_addr <= 32'h3000;
        fetch_req <= 1'b1;
        for (n = 0; !fetch_ack; n++)
        begin
            if (n > 2000)
                tmo();
            @(posedge aclk);
        end
        fetch_req <= 1'b0;
        chk("fetch_data", fetch_data, e);
    endtask
    task automatic t_cache;
        int n;
        axi_wr(OFS_ICACHE_CFG, 32'h101);
        fetch(pat(32'h3000), n);
        rd_chk("miss", OFS_MISS, 32'h1, RESP_OKAY);
        fetch(pat(32'h3000), n);
        rd_chk("hit", OFS_HIT, 32'h1, RESP_OKAY);
        axi_wr(OFS_HIT, 32'hFFFFFFFF);
        rd_chk("hit_clr", OFS_HIT, 32'h0, RESP_OKAY);
        axi_wr(OFS_MISS, 32'h5);
        rd_chk("miss_clr", OFS_MISS, 32'h0, RESP_OKAY);
        axi_wr(OFS_ICACHE_CFG, 32'h1);
        fetch(pat(32'h3000), n);
        rd_chk("prof_off", OFS_HIT, 32'h0, RESP_OKAY);
        axi_wr(OFS_ICACHE_CFG, 32'h0);
        axi_wr(OFS_ICACHE_CFG, 32'h101);
        fetch(pat(32'h3000), n);
        rd_chk("inval", OFS_MISS, 32'h1, RESP_OKAY);
        axi_wr(OFS_CONFIG, 32'h2);
        axi_wr(OFS_PAGE_ERASE, 32'h3000);
        fetch(32'hFFFFFFFF, n);
        chk("stall", 32'(n > 800), 32'h1);
    endtask
    initial
    begin
        ce = 1'b1;
        aresetn = 1'b0;
        {awaddr, araddr, wdata, wstrb} = '0;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        {nvm_wr_req, nvm_wr_addr, nvm_wr_data} = '0;
        {fetch_req, fetch_addr} = '0;
        err_count = 0;
        checked = 0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        t_erase();
        t_partial();
        t_word();
        t_cache();
        print_verdict();
    end
endmodule
`default_nettype wire

// File: nvmec_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module nvmec_ctrl #(
    parameter int MS_CYCLES = nvmec_pkg::MS_CYC_DEFAULT
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic [nvmec_pkg::ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [nvmec_pkg::ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic nvm_wr_req,
    input wire logic [31:0] nvm_wr_addr,
    input wire logic [31:0] nvm_wr_data,
    output logic nvm_wr_taken,
    output logic arr_write,
    output logic arr_page_erase,
    output logic arr_partial_erase,
    output logic arr_all_erase,
    output logic arr_ucfg_erase,
    output logic [31:0] arr_addr,
    output logic [31:0] arr_wdata,
    output logic arr_rd_req,
    output logic [31:0] arr_rd_addr,
    input wire logic arr_rd_valid,
    input wire logic [31:0] arr_rd_data,
    input wire logic fetch_req,
    input wire logic [31:0] fetch_addr,
    output logic fetch_ack,
    output logic [31:0] fetch_data,
    output logic erase_cycle_done
);
    import nvmec_pkg::*;

    // bus slave holding registers
    logic aw_held;
    logic w_held;
    logic [ADDR_W-1:0] waddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;

    // software visible state
    logic [1:0] mode;
    logic [31:0] partial_ms;
    logic icache_on;
    logic profiling_on;
    logic [31:0] cache_hit_counter;
    logic [31:0] cache_miss_counter;

    // sequencer
    nvmec_seq_t seq;
    nvmec_op_t op;
    logic [31:0] cyc_cnt;
    logic [31:0] ms_cnt;
    logic [31:0] target_ms;
    logic [31:0] acc_page;
    logic [31:0] acc_ms;

    // cache
    nvmec_fetch_t fe;
    logic [31:0] cdata [LINES];
    logic [TAG_W-1:0] ctag [LINES];
    logic [LINES-1:0] cvalid;

    wire aw_take = awvalid & awready;
    wire w_take = wvalid & wready;
    wire ar_take = arvalid & arready;
    wire wr_fire = aw_held & w_held & ~bvalid;
    wire next_aw_held = aw_take | (aw_held & ~wr_fire);
    wire next_w_held = w_take | (w_held & ~wr_fire);
    wire next_rvalid = ar_take | (rvalid & ~rready);

    wire [31:0] wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}},
                         {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
    wire [31:0] cfg_word = {23'h000000, profiling_on, 7'h00, icache_on};
    wire [31:0] next_cfg_word = (cfg_word & ~wmask) | (wdata_q & wmask);
    wire [31:0] next_partial = (partial_ms & ~wmask) | (wdata_q & wmask);
    wire [1:0] next_mode = (mode & ~wmask[1:0]) | (wdata_q[1:0] & wmask[1:0]);

    // write decode
    wire hit_page = waddr_q == OFS_PAGE_ERASE;
    wire hit_alias_b = waddr_q == OFS_ALIAS_B;
    wire hit_all = waddr_q == OFS_ERASE_ALL;
    wire hit_ucfg = waddr_q == OFS_UCFG_ERASE;
    wire hit_partial = waddr_q == OFS_PARTIAL;
    wire hit_pcfg = waddr_q == OFS_PARTIAL_CFG;
    wire hit_icfg = waddr_q == OFS_ICACHE_CFG;
    wire hit_hitc = waddr_q == OFS_HIT;
    wire hit_missc = waddr_q == OFS_MISS;
    wire hit_config = waddr_q == OFS_CONFIG;
    wire hit_ready = waddr_q == OFS_READY;
    wire wr_mapped = hit_page | hit_alias_b | hit_all | hit_ucfg
        | hit_partial | hit_pcfg | hit_icfg | hit_hitc | hit_missc
        | hit_config | hit_ready;

    // erase commands need erase mode and an idle sequencer
    wire cmd_ok = wr_fire & (mode == MODE_EEN) & (seq == SEQ_IDLE);
    wire start_page = cmd_ok & (hit_page | hit_alias_b);
    wire start_all = cmd_ok & hit_all;
    wire start_ucfg = cmd_ok & hit_ucfg;
    wire start_partial = cmd_ok & hit_partial;
    wire start_erase = start_page | start_all | start_ucfg | start_partial;
    wire start_wr = nvm_wr_req & (mode == MODE_WEN) & (seq == SEQ_IDLE)
        & ~nvm_wr_taken;

    // timing
    wire ms_tick = cyc_cnt == 32'(MS_CYCLES - 1);
    wire wr_done = (seq == SEQ_WRITE) & (cyc_cnt == 32'(WRITE_CYC - 1));
    wire er_done = (seq == SEQ_ERASE) & ms_tick
        & ((ms_cnt + 32'h00000001) >= target_ms);
    wire op_done = wr_done | er_done;
    wire [31:0] start_ms = start_all ? T_ALL_MS
        : start_partial ? partial_ms : T_PAGE_MS;

    // partial erase accumulation, one page tracked at a time
    wire [31:0] acc_base = (acc_page == arr_addr) ? acc_ms : 32'h00000000;
    wire [32:0] acc_sum = {1'b0, acc_base} + {1'b0, target_ms};
    wire acc_full = acc_sum >= {1'b0, T_PAGE_MS};

    // read decode
    wire [31:0] rd_mux =
        (araddr == OFS_READY) ? {31'h00000000, seq == SEQ_IDLE}
        : (araddr == OFS_CONFIG) ? {30'h00000000, mode}
        : (araddr == OFS_PARTIAL_CFG) ? partial_ms
        : (araddr == OFS_ICACHE_CFG) ? cfg_word
        : (araddr == OFS_HIT) ? cache_hit_counter
        : (araddr == OFS_MISS) ? cache_miss_counter
        : 32'h00000000;
    wire rd_mapped = (araddr == OFS_READY) | (araddr == OFS_CONFIG)
        | (araddr == OFS_PAGE_ERASE) | (araddr == OFS_ERASE_ALL)
        | (araddr == OFS_ALIAS_B) | (araddr == OFS_UCFG_ERASE)
        | (araddr == OFS_PARTIAL) | (araddr == OFS_PARTIAL_CFG)
        | (araddr == OFS_ICACHE_CFG) | (araddr == OFS_HIT)
        | (araddr == OFS_MISS);

    // cache lookup
    wire [IDX_W-1:0] f_idx = fetch_addr[IDX_W+1:2];
    wire [TAG_W-1:0] f_tag = fetch_addr[31:IDX_W+2];
    wire [IDX_W-1:0] m_idx = arr_rd_addr[IDX_W+1:2];
    wire c_hit = icache_on & cvalid[f_idx] & (ctag[f_idx] == f_tag);
    // no new fetch is served while the array is being changed
    wire f_start = fetch_req & ~fetch_ack & (fe == FE_IDLE)
        & (seq == SEQ_IDLE) & ~start_erase & ~start_wr;
    wire f_hit = f_start & c_hit;
    wire f_miss = f_start & ~c_hit;
    wire fill = (fe == FE_MISS) & arr_rd_valid;

    wire inc_hit = profiling_on & f_hit;
    wire inc_miss = profiling_on & f_miss;
    wire clr_hit = wr_fire & hit_hitc;
    wire clr_miss = wr_fire & hit_missc;
    // a count that lands with the clear survives as one
    wire [31:0] next_hit = clr_hit ? {31'h00000000, inc_hit}
        : (inc_hit & ~&cache_hit_counter) ? cache_hit_counter + 32'h00000001
        : cache_hit_counter;
    wire [31:0] next_miss = clr_miss ? {31'h00000000, inc_miss}
        : (inc_miss & ~&cache_miss_counter) ? cache_miss_counter + 32'h00000001
        : cache_miss_counter;

    // bus slave
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            awready <= 1'b0;
            wready <= 1'b0;
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= 32'h00000000;
            rresp <= RESP_OKAY;
            waddr_q <= 12'h000;
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
        end
        else if (ce)
        begin
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            awready <= ~next_aw_held;
            wready <= ~next_w_held;
            arready <= ~next_rvalid;
            rvalid <= next_rvalid;
            if (aw_take)
                waddr_q <= {awaddr[ADDR_W-1:2], 2'b00};
            if (w_take)
            begin
                wdata_q <= wdata;
                wstrb_q <= wstrb;
            end
            if (wr_fire)
            begin
                bvalid <= 1'b1;
                bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
            end
            else if (bready)
                bvalid <= 1'b0;
            if (ar_take)
            begin
                rdata <= rd_mux;
                rresp <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    // software registers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            mode <= CONFIG_RESET;
            partial_ms <= PARTIAL_CFG_RESET;
            icache_on <= ICACHE_CFG_RESET[CACHE_EN_BIT];
            profiling_on <= ICACHE_CFG_RESET[PROF_EN_BIT];
            cache_hit_counter <= COUNTER_RESET;
            cache_miss_counter <= COUNTER_RESET;
        end
        else if (ce)
        begin
            if (wr_fire & hit_config)
                mode <= next_mode;
            if (wr_fire & hit_pcfg)
                partial_ms <= next_partial;
            if (wr_fire & hit_icfg)
            begin
                icache_on <= next_cfg_word[CACHE_EN_BIT];
                profiling_on <= next_cfg_word[PROF_EN_BIT];
            end
            cache_hit_counter <= next_hit;
            cache_miss_counter <= next_miss;
        end
    end

    // write and erase sequencer
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            seq <= SEQ_IDLE;
            op <= OP_PAGE;
            cyc_cnt <= 32'h00000000;
            ms_cnt <= 32'h00000000;
            target_ms <= 32'h00000000;
            arr_addr <= 32'h00000000;
            arr_wdata <= 32'h00000000;
            nvm_wr_taken <= 1'b0;
        end
        else if (ce)
        begin
            nvm_wr_taken <= start_wr;
            case (seq)
                SEQ_IDLE:
                begin
                    cyc_cnt <= 32'h00000000;
                    ms_cnt <= 32'h00000000;
                    if (start_erase)
                    begin
                        seq <= SEQ_ERASE;
                        op <= start_all ? OP_ALL : start_ucfg ? OP_UCFG
                            : start_partial ? OP_PARTIAL : OP_PAGE;
                        target_ms <= start_ms;
                        arr_addr <= wdata_q;
                    end
                    else if (start_wr)
                    begin
                        seq <= SEQ_WRITE;
                        op <= OP_WRITE;
                        arr_addr <= nvm_wr_addr;
                        arr_wdata <= nvm_wr_data;
                    end
                end
                SEQ_WRITE:
                begin
                    cyc_cnt <= cyc_cnt + 32'h00000001;
                    if (wr_done)
                        seq <= SEQ_IDLE;
                end
                SEQ_ERASE:
                begin
                    cyc_cnt <= ms_tick ? 32'h00000000
                        : cyc_cnt + 32'h00000001;
                    if (ms_tick)
                        ms_cnt <= ms_cnt + 32'h00000001;
                    // the array fills the region with ones once the op starts
                    if (er_done)
                        seq <= SEQ_IDLE;
                end
                default:
                    seq <= SEQ_IDLE;
            endcase
        end
    end

    // array strobes and partial erase bookkeeping
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            arr_write <= 1'b0;
            arr_page_erase <= 1'b0;
            arr_partial_erase <= 1'b0;
            arr_all_erase <= 1'b0;
            arr_ucfg_erase <= 1'b0;
            acc_page <= 32'h00000000;
            acc_ms <= 32'h00000000;
            erase_cycle_done <= 1'b0;
        end
        else if (ce)
        begin
            arr_write <= start_wr | (arr_write & ~wr_done);
            arr_page_erase <= start_page | (arr_page_erase & ~er_done);
            arr_partial_erase <= start_partial
                | (arr_partial_erase & ~er_done);
            arr_all_erase <= start_all | (arr_all_erase & ~er_done);
            arr_ucfg_erase <= start_ucfg | (arr_ucfg_erase & ~er_done);
            erase_cycle_done <= er_done
                & ((op == OP_PARTIAL) ? acc_full : (op != OP_UCFG));
            if (er_done & (op == OP_PARTIAL))
            begin
                acc_page <= arr_addr;
                acc_ms <= acc_full ? 32'h00000000 : acc_sum[31:0];
            end
            else if (er_done & ((op == OP_ALL)
                | ((op == OP_PAGE) & (acc_page == arr_addr))))
                acc_ms <= 32'h00000000;
        end
    end

    // instruction fetch path
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            fe <= FE_IDLE;
            fetch_ack <= 1'b0;
            fetch_data <= 32'h00000000;
            arr_rd_req <= 1'b0;
            arr_rd_addr <= 32'h00000000;
            cvalid <= '0;
        end
        else if (ce)
        begin
            fetch_ack <= f_hit | fill;
            case (fe)
                FE_IDLE:
                begin
                    if (f_hit)
                        fetch_data <= cdata[f_idx];
                    else if (f_miss)
                    begin
                        fe <= FE_MISS;
                        arr_rd_req <= 1'b1;
                        arr_rd_addr <= fetch_addr;
                    end
                end
                FE_MISS:
                begin
                    if (fill)
                    begin
                        fe <= FE_IDLE;
                        arr_rd_req <= 1'b0;
                        fetch_data <= arr_rd_data;
                    end
                end
                default:
                    fe <= FE_IDLE;
            endcase
            // stale lines after any array change are dropped wholesale
            if (!icache_on || op_done)
                cvalid <= '0;
            else if (fill)
                cvalid[m_idx] <= 1'b1;
        end
    end

    // line storage carries no reset; validity guards it
    always_ff @(posedge aclk)
    begin
        if (ce && fill && icache_on)
        begin
            cdata[m_idx] <= arr_rd_data;
            ctag[m_idx] <= arr_rd_addr[31:IDX_W+2];
        end
    end
endmodule
`default_nettype wire

// File: nvmec_ctrl_properties.sv
`timescale 1ns/1ps
`default_nettype none
module nvmec_ctrl_chk #(
    parameter int MS_CYCLES = 10000
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic bvalid,
    input wire logic nvm_wr_taken,
    input wire logic arr_write,
    input wire logic arr_page_erase,
    input wire logic arr_partial_erase,
    input wire logic arr_all_erase,
    input wire logic arr_ucfg_erase,
    input wire logic fetch_ack,
    input wire logic erase_cycle_done
);
    logic [31:0] wcnt;
    logic [31:0] ecnt;
    wire logic ers = arr_page_erase | arr_partial_erase | arr_all_erase
        | arr_ucfg_erase;
    // run lengths; a fall caused by reset is masked by $past(aresetn)
    always_ff @(posedge aclk)
    begin
        wcnt <= (aresetn && arr_write) ? wcnt + 32'h1 : 32'h0;
        ecnt <= (aresetn && ers) ? ecnt + 32'h1 : 32'h0;
    end
    default clocking dc @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_wr_len;
        $fell(arr_write) && $past(aresetn) |-> wcnt == 410;
    endproperty
    a_wr_len: assert property (p_wr_len)
        else $error("word write length wrong");
    property p_wr_tk;
        nvm_wr_taken |-> arr_write ##1 !nvm_wr_taken;
    endproperty
    a_wr_tk: assert property (p_wr_tk)
        else $error("write accept pulse wrong");
    property p_pg_len;
        $fell(arr_page_erase) && $past(aresetn) |-> ecnt == 85 * MS_CYCLES;
    endproperty
    a_pg_len: assert property (p_pg_len)
        else $error("page erase length wrong");
    property p_all_len;
        $fell(arr_all_erase) && $past(aresetn) |-> ecnt == 169 * MS_CYCLES;
    endproperty
    a_all_len: assert property (p_all_len)
        else $error("erase-all length wrong");
    property p_uc_len;
        $fell(arr_ucfg_erase) && $past(aresetn) |-> ecnt == 85 * MS_CYCLES;
    endproperty
    a_uc_len: assert property (p_uc_len)
        else $error("user area erase length wrong");
    property p_pt_len;
        $fell(arr_partial_erase) && $past(aresetn)
            |-> ecnt != 0 && ecnt % MS_CYCLES == 0;
    endproperty
    a_pt_len: assert property (p_pt_len)
        else $error("partial step length wrong");
    property p_pg_done;
        $fell(arr_page_erase) && $past(aresetn) |-> ##[0:1] erase_cycle_done;
    endproperty
    a_pg_done: assert property (p_pg_done)
        else $error("no erase cycle pulse");
    property p_cmd;
        $rose(arr_page_erase) |-> $rose(bvalid);
    endproperty
    a_cmd: assert property (p_cmd)
        else $error("page erase without bus command");
    property p_stall;
        ers || arr_write |-> !fetch_ack;
    endproperty
    a_stall: assert property (p_stall)
        else $error("fetch served while busy");
endmodule
bind nvmec_ctrl nvmec_ctrl_chk #(.MS_CYCLES(MS_CYCLES)) nvmec_ctrl_chk_i (
    .aclk(aclk), .aresetn(aresetn), .bvalid(bvalid),
    .nvm_wr_taken(nvm_wr_taken), .arr_write(arr_write),
    .arr_page_erase(arr_page_erase), .arr_partial_erase(arr_partial_erase),
    .arr_all_erase(arr_all_erase), .arr_ucfg_erase(arr_ucfg_erase),
    .fetch_ack(fetch_ack), .erase_cycle_done(erase_cycle_done)
);
`default_nettype wire

// File: nvmec_flash_model.sv
`timescale 1ns/1ps
`default_nettype none
module nvmec_flash_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic arr_rd_req,
    input wire logic [31:0] arr_rd_addr,
    input wire logic wipe,
    input wire logic prog,
    output logic arr_rd_valid,
    output logic [31:0] arr_rd_data
);
    logic [1:0] cnt;
    logic slow;
    logic blank;
    // answers alternate between prompt and three wait cycles
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cnt <= 2'h0;
            slow <= 1'b0;
            blank <= 1'b0;
            arr_rd_valid <= 1'b0;
            arr_rd_data <= 32'h0;
        end
        else
        begin
            if (wipe)
                blank <= 1'b1;
            else if (prog)
                blank <= 1'b0;
            if (arr_rd_req && !arr_rd_valid && cnt == {slow, slow})
            begin
                arr_rd_valid <= 1'b1;
                arr_rd_data <= blank ? 32'hFFFFFFFF
                    : {arr_rd_addr[15:0], ~arr_rd_addr[15:0]};
                cnt <= 2'h0;
                slow <= ~slow;
            end
            else
            begin
                arr_rd_valid <= 1'b0;
                // stale data must not look valid
                arr_rd_data <= ~arr_rd_data;
                if (arr_rd_req && !arr_rd_valid)
                    cnt <= cnt + 2'h1;
            end
        end
    end
endmodule
`default_nettype wire

// File: nvmec_pkg.sv
package nvmec_pkg;
    localparam int ADDR_W = 12;
    localparam logic [11:0] OFS_READY = 12'h400;
    localparam logic [11:0] OFS_CONFIG = 12'h504;
    localparam logic [11:0] OFS_PAGE_ERASE = 12'h508;
    localparam logic [11:0] OFS_ERASE_ALL = 12'h50C;
    localparam logic [11:0] OFS_ALIAS_B = 12'h510;
    localparam logic [11:0] OFS_UCFG_ERASE = 12'h514;
    localparam logic [11:0] OFS_PARTIAL = 12'h518;
    localparam logic [11:0] OFS_PARTIAL_CFG = 12'h51C;
    localparam logic [11:0] OFS_ICACHE_CFG = 12'h540;
    localparam logic [11:0] OFS_HIT = 12'h548;
    localparam logic [11:0] OFS_MISS = 12'h54C;

    localparam logic [31:0] PARTIAL_CFG_RESET = 32'h0000000A;
    localparam logic [31:0] ICACHE_CFG_RESET = 32'h00000000;
    localparam logic [31:0] COUNTER_RESET = 32'h00000000;
    localparam logic [1:0] CONFIG_RESET = 2'h0;
    localparam int CACHE_EN_BIT = 0;
    localparam int PROF_EN_BIT = 8;

    localparam logic [1:0] MODE_READ = 2'h0;
    localparam logic [1:0] MODE_WEN = 2'h1;
    localparam logic [1:0] MODE_EEN = 2'h2;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    localparam int CLK_HZ = 10_000_000;
    localparam int T_WRITE_US = 41;
    localparam int WRITE_CYC = (T_WRITE_US * (CLK_HZ / 1_000_000) < 1) ? 1
        : T_WRITE_US * (CLK_HZ / 1_000_000);
    localparam int MS_CYC_DEFAULT = CLK_HZ / 1000;
    localparam logic [31:0] T_PAGE_MS = 32'h00000055;
    localparam logic [31:0] T_ALL_MS = 32'h000000A9;

    localparam int CACHE_BYTES = 2048;
    localparam int LINES = CACHE_BYTES / 4;
    localparam int IDX_W = $clog2(LINES);
    localparam int TAG_W = 32 - IDX_W - 2;

    typedef enum logic [1:0] {SEQ_IDLE, SEQ_WRITE, SEQ_ERASE} nvmec_seq_t;
    typedef enum logic [2:0] {
        OP_WRITE, OP_PAGE, OP_PARTIAL, OP_ALL, OP_UCFG
    } nvmec_op_t;
    typedef enum logic {FE_IDLE, FE_MISS} nvmec_fetch_t;
endpackage
